// ---- hw/hup_pkg.sv ----
// shared constants and helpers of the host register port
package hup_pkg;

	// ----------------------------------------------------------------
	// clocking and rate generation
	// ----------------------------------------------------------------
	localparam int unsigned SYS_FREQ_10KHZ = 4000; // clk_sys, 40 MHz
	localparam int unsigned OSC_FREQ_10KHZ = 2712; // rate reference, 27.12 MHz
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned ACC_W = 21;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(OSC_FREQ_10KHZ);
	localparam int unsigned TICK_SCALE = SYS_FREQ_10KHZ / OVERSAMPLE;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam logic [3:0] LAST_SAMPLE = 4'hF;
	localparam int unsigned MANT_OFFSET = 33;

	// ----------------------------------------------------------------
	// registers and fields
	// ----------------------------------------------------------------
	localparam logic [5:0] RATE_REG_IDX = 6'h1F;
	localparam logic [7:0] RATE_RESET = 8'hEB; // 9.6 kBd
	localparam int unsigned EXP_LSB = 5;
	localparam int unsigned EXP_W = 3;
	localparam int unsigned MANT_LSB = 0;
	localparam int unsigned MANT_W = 5;
	localparam int unsigned DIR_BIT = 7;
	localparam int unsigned REG_ADDR_W = 6;
	localparam int unsigned REG_DEPTH = 64;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned WREQ_W = REG_ADDR_W + DATA_W;

	// ----------------------------------------------------------------
	// i2c slave address and pin handling
	// ----------------------------------------------------------------
	localparam logic [3:0] I2C_FIXED_UPPER = 4'h5; // 0101b
	localparam logic [1:0] SPIKE_CYCLES = 2'h2;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam int unsigned SYNC_W = 11;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h007;

	// ----------------------------------------------------------------
	// write buffering
	// ----------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [1:0] WR_SLOT_LAST = 2'h3;

	// 16x sample threshold of the rate accumulator for a setting
	function automatic logic [ACC_W-1:0] hup_rate_threshold(
		input logic [7:0] setting
	);
		logic [EXP_W-1:0] e;
		logic [ACC_W-1:0] d;
		e = setting[EXP_LSB +: EXP_W];
		if (e == 3'h0)
			d = ACC_W'(setting[MANT_LSB +: MANT_W]) + ACC_W'(1);
		else
			d = (ACC_W'(setting[MANT_LSB +: MANT_W]) + ACC_W'(MANT_OFFSET))
				<< (e - 3'h1);
		return ACC_W'(d * ACC_W'(TICK_SCALE));
	endfunction

endpackage

// ---- hw/hup_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module hup_fifo #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [PW:0] count_r, count_nxt;
	logic doPush, doPop;

	// ----------------------------------------------------------------
	// pointers and fill level
	// ----------------------------------------------------------------
	always_comb
	begin
		inReady = (count_r != (PW+1)'(DEPTH));
		outValid = (count_r != '0);
		outData = store[rdPtr_r];
		doPush = inValid && inReady;
		doPop = outValid && outReady;
		wrPtr_nxt = doPush ? PW'((wrPtr_r + 1'b1) % DEPTH) : wrPtr_r;
		rdPtr_nxt = doPop ? PW'((rdPtr_r + 1'b1) % DEPTH) : rdPtr_r;
		count_nxt = count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end

	// storage needs no reset
	always_ff @(posedge clk_sys)
	begin
		if (doPush)
			store[wrPtr_r] <= inData;
	end

endmodule

// ---- hw/hup_reg_mem.sv ----
// register file storage, one write port, registered read port
`timescale 1ns/10ps
module hup_reg_mem
	import hup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [REG_ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic rdEn,
	input wire logic [REG_ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);

	logic [DATA_W-1:0] cells [REG_DEPTH];

	// write and registered read
	always_ff @(posedge clk_sys)
	begin
		if (wrEn)
			cells[wrAddr] <= wrData;
		if (rdEn)
			rdData <= cells[rdAddr];
	end

endmodule

// ---- hw/hup_register_port.sv ----
// uart and i2c host access to the shared register file
`timescale 1ns/10ps

// Functional notes
// - after reset the uart runs at 9.6 kBd until reprogrammed
// - rate register holds 3-bit exponent and 5-bit mantissa
// - exp 0: 27.12 MHz/(m+1), else 27.12 MHz/((m+33)*2^(exp-1))
// - standard rates stay within 1.5 percent of nominal
// - uart character: start 0, eight data bits, stop 1, no parity
// - uart bytes travel least significant bit first
// - uart read: address byte in, one register data byte out
// - uart write: address then data; address echoed during data
// - address byte: bit 7 read, bit 6 reserved, bits 5:0 register
// - i2c is slave only: no clock drive, no arbitration
// - i2c slave receives and transmits up to 3.4 Mbit/s
// - sda only pulled low or released
// - spike filtering on scl and sda when i2c is selected
// - start and stop detected with scl high; repeated start same
// - sda changes only while scl is low
// - i2c bytes msb first, each with acknowledge, unlimited count
// - receiver holds sda low through the acknowledge clock
// - missing master acknowledge ends slave transmission
// - mode pin low: address 0101b plus three address pins
// - mode pin high: six address pins, bit 6 zero
// - slave address latched once after reset release
// - i2c write: register address byte, then data to same register
// - i2c read frame returns bytes from the register last addressed
module hup_register_port
	import hup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic uartRxPin,
	output logic uartTxPin,
	input wire logic i2cSelPin,
	input wire logic sclPin,
	input wire logic sdaInPin,
	output logic sdaOutPin,
	output logic sdaOePin,
	input wire logic addrModeSelect,
	input wire logic [5:0] addrPins,
	output logic [6:0] i2cSlaveAddr,
	output logic [7:0] activeRateSetting
);

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001, RX_START = 4'b0010,
		RX_DATA = 4'b0100, RX_STOP = 4'b1000
	} hup_rx_t;
	typedef enum logic [4:0] {
		UC_ADDR = 5'b00001, UC_READ = 5'b00010, UC_DATA = 5'b00100,
		UC_PUSH = 5'b01000, UC_DRAIN = 5'b10000
	} hup_uc_t;
	typedef enum logic [5:0] {
		I_IDLE = 6'b000001, I_ADDR = 6'b000010, I_ACK = 6'b000100,
		I_RX = 6'b001000, I_TX = 6'b010000, I_TXACK = 6'b100000
	} hup_i2c_t;

	// ----------------------------------------------------------------
	// pin synchronisers and strap latch
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_r, sync2_r;
	logic [1:0] strapCnt_r, strapCnt_nxt;
	logic strapDone_r, strapDone_nxt;
	logic [6:0] slaveAddr_r, slaveAddr_nxt;
	logic rxLine, selI2c;

	assign rxLine = sync2_r[2];
	assign selI2c = sync2_r[3];

	// strap capture a few cycles after release, never again
	always_comb
	begin
		strapCnt_nxt = strapCnt_r;
		strapDone_nxt = strapDone_r;
		slaveAddr_nxt = slaveAddr_r;
		if (!strapDone_r)
		begin
			strapCnt_nxt = strapCnt_r + 2'h1;
			if (strapCnt_r == STRAP_SETTLE)
			begin
				strapDone_nxt = 1'b1;
				if (sync2_r[10])
					slaveAddr_nxt = {1'b0, sync2_r[9:4]};
				else
					slaveAddr_nxt = {I2C_FIXED_UPPER, sync2_r[6:4]};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_r <= SYNC_RESET;
			sync2_r <= SYNC_RESET;
			strapCnt_r <= '0;
			strapDone_r <= 1'b0;
			slaveAddr_r <= '0;
		end
		else
		begin
			sync1_r <= {addrModeSelect, addrPins, i2cSelPin, uartRxPin,
				sclPin, sdaInPin};
			sync2_r <= sync1_r;
			strapCnt_r <= strapCnt_nxt;
			strapDone_r <= strapDone_nxt;
			slaveAddr_r <= slaveAddr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// rate generator, 16 ticks per uart bit
	// ----------------------------------------------------------------
	logic [ACC_W-1:0] acc_r, acc_nxt, accSum, thresh;
	logic [7:0] rate_r, rate_nxt, rateShadow_r, rateShadow_nxt;
	logic tick;

	// fractional accumulator keeps the mean rate exact
	always_comb
	begin
		thresh = hup_rate_threshold(rate_r);
		accSum = acc_r + ACC_STEP;
		tick = (accSum >= thresh);
		acc_nxt = tick ? (accSum - thresh) : accSum;
	end

	// ----------------------------------------------------------------
	// uart receiver
	// ----------------------------------------------------------------
	hup_rx_t rxSt_r, rxSt_nxt;
	logic [3:0] rxCnt_r, rxCnt_nxt;
	logic [2:0] rxBit_r, rxBit_nxt;
	logic [7:0] rxShift_r, rxShift_nxt;
	logic rxDone_r, rxDone_nxt;

	always_comb
	begin
		rxSt_nxt = rxSt_r;
		rxCnt_nxt = rxCnt_r;
		rxBit_nxt = rxBit_r;
		rxShift_nxt = rxShift_r;
		rxDone_nxt = 1'b0;
		case (rxSt_r)
			RX_IDLE:
				if (!rxLine && !selI2c)
				begin
					rxSt_nxt = RX_START;
					rxCnt_nxt = '0;
				end
			RX_START:
				if (tick)
				begin
					rxCnt_nxt = rxCnt_r + 4'h1;
					if (rxCnt_r == MID_SAMPLE)
					begin
						rxCnt_nxt = '0;
						rxBit_nxt = '0;
						rxSt_nxt = rxLine ? RX_IDLE : RX_DATA;
					end
				end
			RX_DATA:
				if (tick)
				begin
					rxCnt_nxt = rxCnt_r + 4'h1;
					if (rxCnt_r == LAST_SAMPLE)
					begin
						rxShift_nxt = {rxLine, rxShift_r[7:1]};
						rxBit_nxt = rxBit_r + 3'h1;
						if (rxBit_r == 3'h7)
							rxSt_nxt = RX_STOP;
					end
				end
			RX_STOP:
				// a dropped byte waits for the line to rise, no false start
				if (rxBit_r != 3'h0)
				begin
					if (rxLine)
						rxSt_nxt = RX_IDLE;
				end
				else if (tick)
				begin
					rxCnt_nxt = rxCnt_r + 4'h1;
					if (rxCnt_r == LAST_SAMPLE)
					begin
						// bad stop bit drops the byte
						rxDone_nxt = rxLine;
						rxSt_nxt = rxLine ? RX_IDLE : RX_STOP;
						rxBit_nxt = rxLine ? 3'h0 : 3'h1;
					end
				end
			default:
				rxSt_nxt = RX_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// uart transmitter and transaction control
	// ----------------------------------------------------------------
	hup_uc_t ucSt_r, ucSt_nxt;
	logic [9:0] txShift_r, txShift_nxt;
	logic [3:0] txCnt_r, txCnt_nxt, txBits_r, txBits_nxt;
	logic txBusy_r, txBusy_nxt, uartTx_r, uartTx_nxt;
	logic [REG_ADDR_W-1:0] ucAddr_r, ucAddr_nxt;
	logic [DATA_W-1:0] ucData_r, ucData_nxt;
	logic txLoad, ucPush, ucRdReq;
	logic [7:0] txByte;
	logic rdValid_r, rdIsRate_r;
	logic [DATA_W-1:0] memQ, rdData;
	logic fifoInReady;

	assign rdData = rdIsRate_r ? rateShadow_r : memQ;

	always_comb
	begin
		ucSt_nxt = ucSt_r;
		ucAddr_nxt = ucAddr_r;
		ucData_nxt = ucData_r;
		txLoad = 1'b0;
		txByte = rdData;
		ucPush = 1'b0;
		ucRdReq = 1'b0;
		rate_nxt = rate_r;
		case (ucSt_r)
			UC_ADDR:
			begin
				if (!txBusy_r && rxSt_r == RX_IDLE)
					rate_nxt = rateShadow_r;
				if (rxDone_r)
				begin
					ucAddr_nxt = rxShift_r[REG_ADDR_W-1:0];
					if (rxShift_r[DIR_BIT])
						ucSt_nxt = UC_READ;
					else
					begin
						txLoad = 1'b1;
						txByte = rxShift_r;
						ucSt_nxt = UC_DATA;
					end
				end
			end
			UC_READ:
			begin
				ucRdReq = 1'b1;
				if (rdValid_r)
				begin
					txLoad = 1'b1;
					ucSt_nxt = UC_DRAIN;
				end
			end
			UC_DATA:
				if (rxDone_r)
				begin
					ucData_nxt = rxShift_r;
					ucSt_nxt = UC_PUSH;
				end
			UC_PUSH:
			begin
				ucPush = 1'b1;
				if (fifoInReady)
					ucSt_nxt = UC_DRAIN;
			end
			UC_DRAIN:
				if (!txBusy_r)
					ucSt_nxt = UC_ADDR;
			default:
				ucSt_nxt = UC_ADDR;
		endcase
	end

	// start, eight bits lsb first, stop
	always_comb
	begin
		txShift_nxt = txShift_r;
		txCnt_nxt = txCnt_r;
		txBits_nxt = txBits_r;
		txBusy_nxt = txBusy_r;
		if (txLoad)
		begin
			txShift_nxt = {1'b1, txByte, 1'b0};
			txCnt_nxt = '0;
			txBits_nxt = '0;
			txBusy_nxt = 1'b1;
		end
		else if (txBusy_r && tick)
		begin
			txCnt_nxt = txCnt_r + 4'h1;
			if (txCnt_r == LAST_SAMPLE)
			begin
				txShift_nxt = {1'b1, txShift_r[9:1]};
				txBits_nxt = txBits_r + 4'h1;
				if (txBits_r == 4'h9)
					txBusy_nxt = 1'b0;
			end
		end
		uartTx_nxt = txBusy_nxt ? txShift_nxt[0] : 1'b1;
	end

	// ----------------------------------------------------------------
	// i2c spike filter and bus conditions
	// ----------------------------------------------------------------
	logic [1:0] filt_r, filt_nxt, prev_r;
	logic [1:0] spikeCnt_r [2];
	logic [1:0] spikeCnt_nxt [2];
	logic sclRise, sclFall, startCond, stopCond;

	// short filter keeps 3.4 Mbit/s phases
	// a level must hold for a while before it is taken
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			filt_nxt[i] = filt_r[i];
			spikeCnt_nxt[i] = '0;
			if (!selI2c)
				filt_nxt[i] = sync2_r[i];
			else if (sync2_r[i] != filt_r[i])
			begin
				spikeCnt_nxt[i] = spikeCnt_r[i] + 2'h1;
				if (spikeCnt_r[i] + 2'h1 >= SPIKE_CYCLES)
				begin
					filt_nxt[i] = sync2_r[i];
					spikeCnt_nxt[i] = '0;
				end
			end
		end
		sclRise = filt_r[1] && !prev_r[1];
		sclFall = !filt_r[1] && prev_r[1];
		// start and stop only while scl is high
		startCond = selI2c && filt_r[1] && prev_r[1] && prev_r[0]
			&& !filt_r[0];
		stopCond = selI2c && filt_r[1] && prev_r[1] && !prev_r[0]
			&& filt_r[0];
	end

	// ----------------------------------------------------------------
	// i2c slave engine
	// ----------------------------------------------------------------
	hup_i2c_t iSt_r, iSt_nxt;
	logic [2:0] iCnt_r, iCnt_nxt;
	logic [7:0] iShift_r, iShift_nxt;
	logic iRead_r, iRead_nxt, iFirst_r, iFirst_nxt, iAck_r, iAck_nxt;
	logic sdaOe_r, sdaOe_nxt;
	logic [REG_ADDR_W-1:0] regPtr_r, regPtr_nxt;
	logic iPush, iRdReq;

	always_comb
	begin
		iSt_nxt = iSt_r;
		iCnt_nxt = iCnt_r;
		iShift_nxt = iShift_r;
		iRead_nxt = iRead_r;
		iFirst_nxt = iFirst_r;
		iAck_nxt = iAck_r;
		sdaOe_nxt = sdaOe_r;
		regPtr_nxt = regPtr_r;
		iPush = 1'b0;
		iRdReq = iRead_r && (iSt_r == I_ACK || iSt_r == I_TXACK);
		if (startCond)
		begin
			iSt_nxt = I_ADDR;
			iCnt_nxt = '0;
			iFirst_nxt = 1'b0;
			sdaOe_nxt = 1'b0;
		end
		else if (stopCond)
		begin
			iSt_nxt = I_IDLE;
			sdaOe_nxt = 1'b0;
		end
		else if (sclRise)
		begin
			if (iSt_r == I_ADDR || iSt_r == I_RX)
				iShift_nxt = {iShift_r[6:0], filt_r[0]};
			if (iSt_r == I_TXACK)
				iAck_nxt = !filt_r[0];
		end
		// sda moves only after scl falls
		else if (sclFall)
		begin
			case (iSt_r)
				I_ADDR:
				begin
					// the scl fall closing the start is not a bit
					if (!iFirst_r)
						iFirst_nxt = 1'b1;
					else
						iCnt_nxt = iCnt_r + 3'h1;
					if (iFirst_r && iCnt_r == 3'h7)
					begin
						if (iShift_r[7:1] == slaveAddr_r)
						begin
							iSt_nxt = I_ACK;
							sdaOe_nxt = 1'b1;
							iRead_nxt = iShift_r[0];
							iFirst_nxt = !iShift_r[0];
						end
						else
							iSt_nxt = I_IDLE;
					end
				end
				I_ACK:
				begin
					iCnt_nxt = '0;
					if (iRead_r)
					begin
						// bytes come from the addressed register
						iSt_nxt = I_TX;
						iShift_nxt = {rdData[6:0], 1'b0};
						sdaOe_nxt = !rdData[7];
					end
					else
					begin
						iSt_nxt = I_RX;
						sdaOe_nxt = 1'b0;
					end
				end
				I_RX:
				begin
					iCnt_nxt = iCnt_r + 3'h1;
					if (iCnt_r == 3'h7)
					begin
						// first byte sets the register pointer
						if (iFirst_r)
						begin
							regPtr_nxt = iShift_r[REG_ADDR_W-1:0];
							iFirst_nxt = 1'b0;
							iSt_nxt = I_ACK;
							sdaOe_nxt = 1'b1;
						end
						else if (fifoInReady)
						begin
							iPush = 1'b1;
							iSt_nxt = I_ACK;
							sdaOe_nxt = 1'b1;
						end
						else
							iSt_nxt = I_IDLE;
					end
				end
				I_TX:
				begin
					iCnt_nxt = iCnt_r + 3'h1;
					iShift_nxt = {iShift_r[6:0], 1'b0};
					// transmitter releases for the ack clock
					sdaOe_nxt = (iCnt_r == 3'h7) ? 1'b0 : !iShift_r[7];
					if (iCnt_r == 3'h7)
						iSt_nxt = I_TXACK;
				end
				I_TXACK:
				begin
					iCnt_nxt = '0;
					if (iAck_r)
					begin
						iSt_nxt = I_TX;
						iShift_nxt = {rdData[6:0], 1'b0};
						sdaOe_nxt = !rdData[7];
					end
					else
					begin
						iSt_nxt = I_IDLE;
						sdaOe_nxt = 1'b0;
					end
				end
				default:
					sdaOe_nxt = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// write buffer, read port and register storage
	// ----------------------------------------------------------------
	logic fifoOutValid, drainReady, rdReq, rdEn;
	logic [WREQ_W-1:0] fifoIn, fifoOut;
	logic [REG_ADDR_W-1:0] rdAddr;
	logic [1:0] slotCnt_r;

	always_comb
	begin
		fifoIn = selI2c ? {regPtr_r, iShift_r} : {ucAddr_r, ucData_r};
		rdReq = selI2c ? iRdReq : ucRdReq;
		rdAddr = selI2c ? regPtr_r : ucAddr_r;
		// reads wait for queued writes so they see fresh data
		rdEn = rdReq && !fifoOutValid;
		drainReady = (slotCnt_r == WR_SLOT_LAST);
		rateShadow_nxt = rateShadow_r;
		// rate register captured from the write stream
		if (fifoOutValid && drainReady
			&& fifoOut[WREQ_W-1:DATA_W] == RATE_REG_IDX)
			rateShadow_nxt = fifoOut[DATA_W-1:0];
	end

	hup_fifo #(
		.WIDTH(WREQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.inValid(ucPush || iPush),
		.inReady(fifoInReady),
		.inData(fifoIn),
		.outValid(fifoOutValid),
		.outReady(drainReady),
		.outData(fifoOut)
	);

	hup_reg_mem u_reg_mem (
		.clk_sys(clk_sys),
		.wrEn(fifoOutValid && drainReady),
		.wrAddr(fifoOut[WREQ_W-1:DATA_W]),
		.wrData(fifoOut[DATA_W-1:0]),
		.rdEn(rdEn),
		.rdAddr(rdAddr),
		.rdData(memQ)
	);

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acc_r <= '0;
			rate_r <= RATE_RESET;
			rateShadow_r <= RATE_RESET;
			rxSt_r <= RX_IDLE;
			rxCnt_r <= '0;
			rxBit_r <= '0;
			rxShift_r <= '0;
			rxDone_r <= 1'b0;
			ucSt_r <= UC_ADDR;
			ucAddr_r <= '0;
			ucData_r <= '0;
			txShift_r <= '1;
			txCnt_r <= '0;
			txBits_r <= '0;
			txBusy_r <= 1'b0;
			uartTx_r <= 1'b1;
			filt_r <= 2'h3;
			prev_r <= 2'h3;
			spikeCnt_r[0] <= '0;
			spikeCnt_r[1] <= '0;
			iSt_r <= I_IDLE;
			iCnt_r <= '0;
			iShift_r <= '0;
			iRead_r <= 1'b0;
			iFirst_r <= 1'b0;
			iAck_r <= 1'b0;
			sdaOe_r <= 1'b0;
			regPtr_r <= '0;
			slotCnt_r <= '0;
			rdValid_r <= 1'b0;
			rdIsRate_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			rate_r <= rate_nxt;
			rateShadow_r <= rateShadow_nxt;
			rxSt_r <= rxSt_nxt;
			rxCnt_r <= rxCnt_nxt;
			rxBit_r <= rxBit_nxt;
			rxShift_r <= rxShift_nxt;
			rxDone_r <= rxDone_nxt;
			ucSt_r <= ucSt_nxt;
			ucAddr_r <= ucAddr_nxt;
			ucData_r <= ucData_nxt;
			txShift_r <= txShift_nxt;
			txCnt_r <= txCnt_nxt;
			txBits_r <= txBits_nxt;
			txBusy_r <= txBusy_nxt;
			uartTx_r <= uartTx_nxt;
			filt_r <= filt_nxt;
			prev_r <= filt_r;
			spikeCnt_r[0] <= spikeCnt_nxt[0];
			spikeCnt_r[1] <= spikeCnt_nxt[1];
			iSt_r <= iSt_nxt;
			iCnt_r <= iCnt_nxt;
			iShift_r <= iShift_nxt;
			iRead_r <= iRead_nxt;
			iFirst_r <= iFirst_nxt;
			iAck_r <= iAck_nxt;
			sdaOe_r <= sdaOe_nxt;
			regPtr_r <= regPtr_nxt;
			slotCnt_r <= slotCnt_r + 2'h1;
			rdValid_r <= rdEn;
			rdIsRate_r <= (rdAddr == RATE_REG_IDX);
		end
	end

	// only pull low or release; scl is never driven
	assign sdaOutPin = 1'b0;
	assign sdaOePin = sdaOe_r;
	assign uartTxPin = uartTx_r;
	assign i2cSlaveAddr = slaveAddr_r;
	assign activeRateSetting = rate_r;

endmodule

// ---- verification/hup_port_assertions.sv ----
// pin-level assertions of the host register port
`timescale 1ns/10ps
module hup_port_checker
	import hup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic uartRxPin,
	input wire logic uartTxPin,
	input wire logic i2cSelPin,
	input wire logic sclPin,
	input wire logic sdaInPin,
	input wire logic sdaOutPin,
	input wire logic sdaOePin,
	input wire logic addrModeSelect,
	input wire logic [5:0] addrPins,
	input wire logic [6:0] i2cSlaveAddr,
	input wire logic [7:0] activeRateSetting
);
	// ----------
	// pin checks
	// ----------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	a_sda_value_zero: assert property (sdaOutPin == 1'b0)
		else $error("sda data not low");
	a_sda_hold_high: assert property (
		$past(sclPin) && sclPin |-> $stable(sdaOePin))
		else $error("sda drive moved in scl high");
	a_sda_edge_low: assert property (
		$changed(sdaOePin) |-> !sclPin)
		else $error("sda drive moved with scl high");
	a_reset_state: assert property ($rose(arst_n) |->
		uartTxPin && !sdaOePin && activeRateSetting == RATE_RESET)
		else $error("bad state after reset");
	a_addr_stays: assert property (
		i2cSlaveAddr != 7'h00 |=> $stable(i2cSlaveAddr))
		else $error("slave address moved");
	a_addr_from_pins: assert property ($changed(i2cSlaveAddr) |->
		i2cSlaveAddr == (addrModeSelect ? {1'b0, addrPins} :
		{I2C_FIXED_UPPER, addrPins[2:0]}))
		else $error("slave address not from straps");
	a_addr_latch_time: assert property ($rose(arst_n) |-> ##4
		i2cSlaveAddr == (addrModeSelect ? {1'b0, addrPins} :
		{I2C_FIXED_UPPER, addrPins[2:0]}))
		else $error("slave address late");
	// rate moves only when lines idle
	a_rate_when_idle: assert property (
		$changed(activeRateSetting) |-> uartTxPin && uartRxPin)
		else $error("rate changed mid character");
	a_start_bit_len: assert property (
		$fell(uartTxPin) |=> !uartTxPin [*2])
		else $error("start bit too short");
endmodule
bind hup_register_port hup_port_checker chk_u (
	.clk_sys, .arst_n, .uartRxPin, .uartTxPin, .i2cSelPin, .sclPin,
	.sdaInPin, .sdaOutPin, .sdaOePin, .addrModeSelect, .addrPins,
	.i2cSlaveAddr, .activeRateSetting
);

// ---- verification/hup_host_model.sv ----
// host model: uart peer and i2c master
`timescale 1ns/10ps
module hup_host_model (
	input wire logic clk_sys,
	input wire logic uartTx,
	input wire logic sdaBus,
	output logic uartRx,
	output logic scl,
	output logic sdaDrv
);
	// -----------
	// host tasks
	// -----------
	real bitNs = 811.21;
	// idle lines, sda released
	initial
	begin
		uartRx = 1'b1;
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	// step to the first clock edge past the target
	task automatic wt(inout real t, input real d);
		t = t + d;
		while ($realtime < t)
			@(posedge clk_sys);
		#2;
	endtask
	task automatic txByte(input logic [7:0] b, input logic stp);
		real t = $realtime;
		uartRx = 1'b0;
		wt(t, bitNs);
		for (int i = 0; i < 9; i++)
		begin
			uartRx = (i < 8) ? b[i] : stp;
			wt(t, bitNs);
		end
		if (!stp)
		begin
			uartRx = 1'b1;
			wt(t, bitNs);
		end
	endtask
	// sample device tx mid-bit, stop in bit 8
	task automatic rxByte(output logic [8:0] r);
		real t;
		for (int n = 0; n < 20000 && uartTx; n++)
			@(posedge clk_sys);
		t = $realtime;
		wt(t, bitNs / 2.0);
		for (int i = 0; i < 9; i++)
		begin
			wt(t, bitNs);
			r[i] = uartTx;
		end
	endtask
	task automatic i2cBit(input logic v, output logic s);
		real t = $realtime;
		wt(t, 150.0);
		sdaDrv = v;
		wt(t, 150.0);
		scl = 1'b1;
		wt(t, 300.0);
		s = sdaBus;
		scl = 1'b0;
	endtask
	task automatic i2cByte(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
			i2cBit(tx[i], rx[i]);
	endtask
	// start or stop with scl high
	task automatic i2cCond(input logic st);
		real t = $realtime;
		wt(t, 150.0);
		sdaDrv = st;
		wt(t, 150.0);
		scl = 1'b1;
		wt(t, 300.0);
		sdaDrv = !st;
		wt(t, 300.0);
		if (st)
			scl = 1'b0;
	endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench of the host register port
`timescale 1ns/10ps
module tb;
	// -----
	// setup
	// -----
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic i2cSelPin = 1'b1;
	logic addrModeSelect;
	logic [5:0] addrPins;
	logic uartRxPin, uartTxPin, sclPin, sdaOutPin, sdaOePin, sdaBus, sdaDrv;
	logic [6:0] i2cSlaveAddr;
	logic [7:0] activeRateSetting;
	logic [8:0] r;
	logic [8:0] a;
	int errors = 0;
	int cmp_count = 0;
	// open drain bus with pull-up
	assign sdaBus = sdaDrv & (sdaOePin ? sdaOutPin : 1'b1);
	// clock
	always #12.5 clk_sys = ~clk_sys;
	hup_register_port dut (.clk_sys, .arst_n, .uartRxPin, .uartTxPin,
		.i2cSelPin, .sclPin, .sdaInPin(sdaBus), .sdaOutPin, .sdaOePin,
		.addrModeSelect, .addrPins, .i2cSlaveAddr, .activeRateSetting);
	hup_host_model h (.clk_sys, .uartTx(uartTxPin), .sdaBus,
		.uartRx(uartRxPin), .scl(sclPin), .sdaDrv);
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic final_report();
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic rst();
		cyc(1);
		arst_n = 1'b0;
		cyc(2);
		arst_n = 1'b1;
		cyc(10);
	endtask
	task automatic strap(input logic m, input logic [5:0] p,
		input logic [6:0] e);
		addrModeSelect = m;
		addrPins = p;
		rst();
		chk({2'h0, i2cSlaveAddr}, {2'h0, e});
	endtask
	task automatic waitRate(input logic [7:0] e);
		for (int i = 0; i < 5000 && activeRateSetting !== e; i++)
			cyc(1);
		chk({1'b0, activeRateSetting}, {1'b0, e});
	endtask
	task automatic uRd(input logic [7:0] ad, input logic [7:0] e);
		fork
			h.txByte(ad, 1'b1);
			h.rxByte(r);
		join
		chk(r, {1'b1, e});
	endtask
	task automatic uWr(input logic [7:0] ad, input logic [7:0] d);
		fork
			begin
				h.txByte(ad, 1'b1);
				h.txByte(d, 1'b1);
			end
			h.rxByte(r);
		join
		chk(r, {1'b1, ad});
	endtask
	task automatic iW(input logic [7:0] b, input logic ack);
		h.i2cByte({b, 1'b1}, a);
		chk({8'h00, a[0]}, {8'h00, ack});
	endtask
	task automatic iR(input logic nack, input logic [7:0] e);
		h.i2cByte({8'hFF, nack}, a);
		chk({1'b0, a[8:1]}, {1'b0, e});
	endtask
	// main sequence
	initial
	begin
		strap(1'b1, 6'h3A, 7'h3A);
		chk({1'b0, activeRateSetting}, 9'h0EB);
		strap(1'b0, 6'h3A, 7'h2A);
		addrPins = ~addrPins;
		addrModeSelect = ~addrModeSelect;
		cyc(8);
		chk({2'h0, i2cSlaveAddr}, 9'h02A);
		h.i2cCond(1'b1);
		iW(8'h56, 1'b1);
		h.i2cCond(1'b0);
		h.i2cCond(1'b1);
		iW(8'h54, 1'b0);
		iW(8'h1F, 1'b0);
		iW(8'h15, 1'b0);
		h.i2cCond(1'b0);
		waitRate(8'h15);
		h.i2cCond(1'b1);
		iW(8'h54, 1'b0);
		iW(8'h05, 1'b0);
		iW(8'hA5, 1'b0);
		iW(8'h3C, 1'b0);
		h.i2cCond(1'b1);
		iW(8'h54, 1'b0);
		iW(8'h05, 1'b0);
		h.i2cCond(1'b1);
		iW(8'h55, 1'b0);
		iR(1'b0, 8'h3C);
		iR(1'b1, 8'h3C);
		cyc(8);
		chk({8'h00, sdaOePin}, 9'h000);
		h.i2cCond(1'b0);
		i2cSelPin = 1'b0;
		cyc(8);
		uRd(8'h9F, 8'h15);
		uRd(8'hDF, 8'h15);
		uRd(8'h85, 8'h3C);
		uWr(8'h1F, 8'h7A);
		waitRate(8'h7A);
		h.bitNs = 8702.06;
		h.txByte(8'h1F, 1'b0);
		uRd(8'h9F, 8'h7A);
		final_report();
	end
	// watchdog
	initial
	begin
		#2ms;
		errors++;
		final_report();
	end
endmodule
